// >>> shared/oct_pkg.sv
// package: constants for the output compare timer
package oct_pkg;
  // =====================================
  // widths and counts
  localparam int CHANNELS = 5;
  localparam int COUNT_WIDTH = 16;
  localparam int PIN_FIRST = 3;
  localparam int PRESCALE_WIDTH = 4;
  // prescale select codes: 00 div1, 01 div4, 10 div8, 11 div16
  localparam logic [1:0] PRESCALE_DIV1 = 2'h0;
  localparam logic [1:0] PRESCALE_DIV4 = 2'h1;
  localparam logic [1:0] PRESCALE_DIV8 = 2'h2;
  localparam logic [1:0] PRESCALE_DIV16 = 2'h3;
  localparam logic [1:0] PRESCALE_RESET = PRESCALE_DIV8;
  // =====================================
  // pin action codes, mode bit high, level bit low
  localparam logic [1:0] ACTION_NONE = 2'h0;
  localparam logic [1:0] ACTION_TOGGLE = 2'h1;
  localparam logic [1:0] ACTION_CLEAR = 2'h2;
  localparam logic [1:0] ACTION_SET = 2'h3;
  // =====================================
  // timing at 200 MHz core clock, counter tick 2 us at div8
  localparam int CLOCK_MHZ = 200;
  localparam int TICK_NS = 2000;
  localparam int TICK_DIV8_CYCLES = TICK_NS * CLOCK_MHZ / 1000;
  localparam int BASE_CYCLES = TICK_DIV8_CYCLES / 8;
  // =====================================
  // reset values
  localparam logic [15:0] COMPARE_RESET = 16'hFFFF;
  localparam logic [15:0] COUNTER_RESET = 16'h0000;
endpackage

// >>> hw/oct_prescaler.sv
// prescaler: makes the counter advance pulse
`timescale 1ns/10ps
module oct_prescaler #(
  parameter int BASE_CYCLES = oct_pkg::BASE_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [1:0] div_sel,
  output logic tick
);
  localparam int BW = $clog2(BASE_CYCLES + 1);
  typedef struct packed {
    logic [BW-1:0] base;
    logic [oct_pkg::PRESCALE_WIDTH-1:0] div;
    logic tick;
  } oct_pre_type;
  oct_pre_type state_reg;
  oct_pre_type state_next;
  logic [oct_pkg::PRESCALE_WIDTH-1:0] div_last;

  initial begin
    if (BASE_CYCLES < 1) begin
      $error("base cycles must be at least one");
    end
  end

  // =====================================
  // division ratio decode
  always_comb begin
    case (div_sel)
      oct_pkg::PRESCALE_DIV1: div_last = 4'h0;
      oct_pkg::PRESCALE_DIV4: div_last = 4'h3;
      oct_pkg::PRESCALE_DIV8: div_last = 4'h7;
      default: div_last = 4'hF;
    endcase
  end

  always_comb begin
    state_next = state_reg;
    state_next.tick = 1'b0;
    if (state_reg.base == BW'(BASE_CYCLES - 1)) begin
      state_next.base = '0;
      // ratio change takes effect at the next base tick; a count already past the new end ticks at once, no wrap
      if (state_reg.div >= div_last) begin // [R4]
        state_next.div = '0;
        state_next.tick = 1'b1;
      end else begin
        state_next.div = state_reg.div + 4'h1;
      end
    end else begin
      state_next.base = state_reg.base + BW'(1);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign tick = state_reg.tick;
endmodule

// >>> hw/oct_channel_match.sv
// comparator bank: one equality level per channel
`timescale 1ns/10ps
module oct_channel_match #(
  parameter int CHANNELS = oct_pkg::CHANNELS
) (
  input wire logic [15:0] count,
  input wire logic [CHANNELS*16-1:0] compare_values,
  output logic [CHANNELS-1:0] equal
);
  // =====================================
  // continuous equality per channel
  for (genvar i = 0; i < CHANNELS; i++) begin : g_cmp
    assign equal[i] = (count == compare_values[i*16 +: 16]); // [R2]
  end
endmodule

// >>> hw/oct_timer.sv
// top: five channel output compare timer with free running counter
//
// What this block does
// R1 - five channels drive pins seven down to three
// R2 - counter equals compare value means match
// R3 - counter wraps to zero and keeps counting
// R4 - prescaler ratio one, four, eight, sixteen
// R5 - divide eight gives two microsecond tick
// R6 - each channel: compare, flag, mask bit
// R7 - channel one drives any selected pin subset
// R8 - channels two-five: mode and level bits
// R9 - match sets the channel's flag
// R10 - pin acts in same cycle as flag
// R11 - interrupt only when mask bit set
// R12 - software sets pin direction and enable; this block has no direction or enable input and only drives PORT_A_OUT
// R13 - channel one drives selected pins to data
// R14 - two-bit code enables channels two-five
// R15 - force applies actions, no flag, no irq
// R16 - channel one may share pins three-six
// R17 - channel five shares capture four register
// R18 - channel one sets or clears, never toggles
// R19 - software clears capture select before use
// R20 - flag cleared by writing one
// R21 - code 10 clears the pin
// R22 - 00 disconnects, 01 toggles, 11 sets
`timescale 1ns/10ps
module oct_timer #(
  parameter int CHANNELS = oct_pkg::CHANNELS,
  parameter int BASE_CYCLES = oct_pkg::BASE_CYCLES
) (
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire logic [1:0] PRESCALE_SEL,
  input wire logic [15:0] COMPARE_WDATA,
  input wire logic [CHANNELS-1:0] COMPARE_WE,
  input wire logic [4:0] MULTI_PIN_SELECT,
  input wire logic [4:0] MULTI_PIN_DATA,
  input wire logic [7:0] TIMER_CONTROL,
  input wire logic [CHANNELS-1:0] TIMER_MASK,
  input wire logic [CHANNELS-1:0] FLAG_CLEAR,
  input wire logic [CHANNELS-1:0] FORCE_COMPARE,
  input wire logic CAPTURE_SELECT,
  input wire logic [15:0] CAPTURE_VALUE,
  input wire logic CAPTURE_STROBE,
  output logic [15:0] FREE_RUNNING_COUNTER,
  output logic [CHANNELS-1:0] MATCH_FLAG,
  output logic [CHANNELS*16-1:0] COMPARE_VALUES,
  output logic [4:0] PORT_A_OUT,
  output logic IRQ
);
  // =====================================
  // elaboration checks
  // the pin map and the control word layout are fixed at five channels
  initial begin
    if (CHANNELS != 5) begin
      $error("timer serves exactly five channels");
    end
    if (BASE_CYCLES < 1) begin
      $error("base cycles must be at least one");
    end
    if (oct_pkg::COUNT_WIDTH != 16) begin
      $error("counter logic is written for sixteen bits");
    end
    if (oct_pkg::PIN_FIRST + CHANNELS != 8) begin
      $error("channels must end on the top port pin");
    end
  end

  // =====================================
  // state
  typedef struct packed {
    // counter value and a marker that it changed on the last edge
    logic [15:0] count; // [R2] [R3]
    logic fresh;
    // per channel compare word and match flag
    logic [CHANNELS-1:0][15:0] compare; // [R6]
    logic [CHANNELS-1:0] flag; // [R6]
    // port pins seven down to three, pin seven in the top bit
    logic [4:0] pins; // [R1]
    logic irq;
  } oct_state_type;

  oct_state_type state_reg;
  oct_state_type state_next;
  logic tick;
  logic [CHANNELS-1:0] equal;
  logic [CHANNELS*16-1:0] compare_flat;
  logic [CHANNELS-1:0] hit;
  logic [CHANNELS-1:0] act;
  logic [CHANNELS-1:0] blocked;
  logic [4:0] pins_work;
  logic [4:0] multi_mask;
  logic [4:0] multi_value;

  // control code for channel n (1..4 here means channels two to five): bits 9-2n down to 8-2n
  function automatic logic [1:0] code_of(input logic [7:0] ctl, input int ch);
    code_of = ctl[(4 - ch) * 2 +: 2]; // [R14]
  endfunction

  // port bit driven by a single-pin channel, channel one is index zero
  function automatic int pin_bit(input int ch);
    pin_bit = 4 - ch; // [R1] [R8]
  endfunction

  // new pin level for one mode/level code
  function automatic logic apply_code(input logic [1:0] code, input logic pin);
    case (code)
      oct_pkg::ACTION_TOGGLE: apply_code = !pin; // [R22]
      oct_pkg::ACTION_CLEAR: apply_code = 1'b0; // [R21]
      oct_pkg::ACTION_SET: apply_code = 1'b1; // [R22]
      default: apply_code = pin; // [R22]
    endcase
  endfunction

  // =====================================
  // submodules
  oct_prescaler #(
    .BASE_CYCLES(BASE_CYCLES)
  ) u_pre (
    .clk(CORE_CLK),
    .reset_n(RESET_N),
    .div_sel(PRESCALE_SEL),
    .tick(tick)
  );

  always_comb begin
    for (int i = 0; i < CHANNELS; i++) begin
      compare_flat[i*16 +: 16] = state_reg.compare[i];
    end
  end

  oct_channel_match #(
    .CHANNELS(CHANNELS)
  ) u_match (
    .count(state_reg.count),
    .compare_values(compare_flat),
    .equal(equal)
  );

  // =====================================
  // match qualification
  // the counter holds each value for a whole prescaled period; only the
  // first core cycle of a value may match, or one compare would fire
  // on every core cycle of that period
  for (genvar i = 0; i < CHANNELS; i++) begin : g_hit
    if (i == CHANNELS - 1) begin : g_shared
      // the shared register is deaf to compares while it serves capture
      assign blocked[i] = CAPTURE_SELECT; // [R17]
    end else begin : g_own
      assign blocked[i] = 1'b0;
    end
    assign hit[i] = equal[i] && state_reg.fresh && !blocked[i]; // [R2] [R9]
    // a forced compare takes the pin path only, never the flag path
    assign act[i] = hit[i] || FORCE_COMPARE[i]; // [R15]
  end

  // =====================================
  // channel one pin request
  // channel one only copies data bits, so it sets or clears but never
  // toggles; pins outside its select mask keep what they held
  always_comb begin
    multi_mask = '0;
    multi_value = '0;
    if (act[0]) begin
      multi_mask = MULTI_PIN_SELECT; // [R7]
      multi_value = MULTI_PIN_DATA; // [R13] [R18]
    end
  end

  // =====================================
  // pin update
  // channel one goes first, so a single-pin channel firing in the same
  // cycle on a shared pin has the last word
  always_comb begin
    pins_work = (state_reg.pins & ~multi_mask) | (multi_value & multi_mask); // [R16]
    for (int ch = 1; ch < CHANNELS; ch++) begin
      if (act[ch]) begin
        pins_work[pin_bit(ch)] = apply_code(code_of(TIMER_CONTROL, ch), pins_work[pin_bit(ch)]); // [R8] [R14]
      end
    end
  end

  // =====================================
  // next state
  always_comb begin
    state_next = state_reg;
    // counter wraps naturally through 16 bits
    state_next.fresh = tick;
    if (tick) begin
      state_next.count = state_reg.count + 16'h0001; // [R3] [R5]
    end
    // compare register writes
    for (int i = 0; i < CHANNELS; i++) begin
      if (COMPARE_WE[i]) begin
        state_next.compare[i] = COMPARE_WDATA; // [R6]
      end
    end
    // capture path into the shared register; a capture wins over a
    // software write in the same cycle
    if (CAPTURE_SELECT && CAPTURE_STROBE) begin
      state_next.compare[CHANNELS-1] = CAPTURE_VALUE; // [R17]
    end
    // flags: set wins over clear
    for (int i = 0; i < CHANNELS; i++) begin
      if (hit[i]) begin
        state_next.flag[i] = 1'b1; // [R9]
      end else if (FLAG_CLEAR[i]) begin
        state_next.flag[i] = 1'b0; // [R20]
      end
    end
    // pins move on the same edge that sets the flag
    state_next.pins = pins_work; // [R10]
    state_next.irq = |(state_next.flag & TIMER_MASK); // [R11]
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_reg <= '0;
      state_reg.count <= oct_pkg::COUNTER_RESET;
      state_reg.compare <= {CHANNELS{oct_pkg::COMPARE_RESET}};
    end else begin
      state_reg <= state_next;
    end
  end

  // =====================================
  // outputs, all straight from the state register
  assign FREE_RUNNING_COUNTER = state_reg.count;
  assign MATCH_FLAG = state_reg.flag;
  assign COMPARE_VALUES = compare_flat;
  assign PORT_A_OUT = state_reg.pins;
  assign IRQ = state_reg.irq;
endmodule

// >>> tb/oct_timer_asserts.sv
// checker: port assertions for the output compare timer
`timescale 1ns/10ps
module oct_timer_asserts (
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire logic [1:0] PRESCALE_SEL,
  input wire logic [15:0] COMPARE_WDATA,
  input wire logic [4:0] COMPARE_WE,
  input wire logic [4:0] MULTI_PIN_SELECT,
  input wire logic [4:0] MULTI_PIN_DATA,
  input wire logic [7:0] TIMER_CONTROL,
  input wire logic [4:0] TIMER_MASK,
  input wire logic [4:0] FLAG_CLEAR,
  input wire logic [15:0] FREE_RUNNING_COUNTER,
  input wire logic [4:0] MATCH_FLAG,
  input wire logic [79:0] COMPARE_VALUES,
  input wire logic [4:0] PORT_A_OUT,
  input wire logic IRQ
);
  // ==========
  // properties, div8 gap assumes the bench's unit base
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);
  chk_count_step: assert property (!$stable(FREE_RUNNING_COUNTER) |->
    FREE_RUNNING_COUNTER == $past(FREE_RUNNING_COUNTER) + 16'h0001) else $error("counter jumped");
  chk_count_wrap: assert property ($past(FREE_RUNNING_COUNTER) == 16'hFFFF &&
    !$stable(FREE_RUNNING_COUNTER) |-> FREE_RUNNING_COUNTER == 16'h0000) else $error("no wrap");
  chk_div_eight: assert property (PRESCALE_SEL == oct_pkg::PRESCALE_DIV8 && !$stable(FREE_RUNNING_COUNTER)
    |=> $stable(FREE_RUNNING_COUNTER)[*7] ##1 !$stable(FREE_RUNNING_COUNTER)) else $error("div8 gap");
  chk_cmp_write: assert property (COMPARE_WE[0] |=>
    COMPARE_VALUES[15:0] == $past(COMPARE_WDATA)) else $error("compare not stored");
  chk_flag_keep: assert property ((~MATCH_FLAG & $past(MATCH_FLAG & ~FLAG_CLEAR)) == 5'h00)
    else $error("flag lost");
  chk_irq_mask: assert property (IRQ |->
    (MATCH_FLAG & $past(TIMER_MASK)) != 5'h00) else $error("irq unmasked");
  chk_pin_two: assert property ($rose(MATCH_FLAG[1]) && $past(TIMER_CONTROL[7]) |->
    PORT_A_OUT[3] == $past(TIMER_CONTROL[6])) else $error("pin six action");
  chk_pin_one: assert property ($rose(MATCH_FLAG[0]) && $past(MULTI_PIN_SELECT[4]) |->
    PORT_A_OUT[4] == $past(MULTI_PIN_DATA[4])) else $error("pin seven data");
  chk_pin_toggle: assert property ($rose(MATCH_FLAG[1]) && $past(TIMER_CONTROL[7:6]) == 2'h1 |->
    PORT_A_OUT[3] != $past(PORT_A_OUT[3])) else $error("pin six no toggle");
endmodule

// >>> tb/testbench.sv
// testbench: directed sequences for the output compare timer
`timescale 1ns/10ps
module testbench;
  // ==========
  // stimulus and instance, unit base keeps the run short
  logic clk = 0;
  logic rst_n = 0;
  logic [1:0] sel = oct_pkg::PRESCALE_DIV1;
  logic [15:0] wd = 16'h0000;
  logic [4:0] we = 0, mps = 0, mpd = 0, msk = 0, clr = 0, frc = 0;
  logic [7:0] ctl = 8'h00;
  logic cap_sel = 1'b0;
  logic cap_stb = 1'b0;
  logic [15:0] cap_val = 16'h0000;
  int k;
  wire logic [79:0] cv;
  wire logic [15:0] cnt;
  wire logic [4:0] flg, pa;
  wire logic irq;
  int fail_count = 0;
  int n_tests = 0;
  always #2.5 clk = ~clk;
  oct_timer #(.BASE_CYCLES(1)) oct_timer_i (.CORE_CLK(clk), .RESET_N(rst_n), .PRESCALE_SEL(sel),
    .COMPARE_WDATA(wd), .COMPARE_WE(we), .MULTI_PIN_SELECT(mps), .MULTI_PIN_DATA(mpd),
    .TIMER_CONTROL(ctl), .TIMER_MASK(msk), .FLAG_CLEAR(clr), .FORCE_COMPARE(frc),
    .CAPTURE_SELECT(cap_sel), .CAPTURE_VALUE(cap_val), .CAPTURE_STROBE(cap_stb),
    .FREE_RUNNING_COUNTER(cnt), .MATCH_FLAG(flg), .COMPARE_VALUES(cv), .PORT_A_OUT(pa), .IRQ(irq));
  task check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %h not %h", $time, seen, exp);
    end
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ==========
  // compare armed thirty ticks ahead, then wait for its flag
  task hit(input int ch);
    int i;
    @(posedge clk);
    wd <= cnt + 16'h001E;
    we <= 5'h01 << ch;
    @(posedge clk);
    we <= 5'h00;
    for (i = 0; i < 200 && flg[ch] !== 1'b1; i++) @(posedge clk) #1;
    check(flg[ch], 16'h0001);
  endtask
  task clear_flags;
    @(posedge clk);
    clr <= 5'h1F;
    @(posedge clk);
    clr <= 5'h00;
    #1 check(flg, 16'h0000);
  endtask
  initial begin
    #450000;
    fail_count++;
    complete_run;
  end
  initial begin
    repeat (20) @(posedge clk);
    check(cnt, 16'h0000);
    rst_n <= 1'b1;
    ctl <= {oct_pkg::ACTION_SET, 6'h00};
    hit(1);
    check(pa[3], 16'h0001);
    check(irq, 16'h0000);
    clear_flags;
    ctl <= {oct_pkg::ACTION_TOGGLE, 6'h00};
    msk <= 5'h02;
    hit(1);
    check(pa[3], 16'h0000);
    check(irq, 16'h0001);
    clear_flags;
    msk <= 5'h00;
    ctl <= {oct_pkg::ACTION_SET, 6'h00};
    frc <= 5'h02;
    @(posedge clk);
    frc <= 5'h00;
    repeat (2) @(posedge clk);
    check(pa[3], 16'h0001);
    check(flg, 16'h0000);
    check(irq, 16'h0000);
    ctl <= {oct_pkg::ACTION_CLEAR, 6'h00};
    hit(1);
    check(pa[3], 16'h0000);
    clear_flags;
    ctl <= {6'h00, oct_pkg::ACTION_NONE};
    mps <= 5'h1F;
    mpd <= 5'h15;
    hit(0);
    check(pa, 16'h0015);
    clear_flags;
    mps <= 5'h00;
    ctl <= {6'h00, oct_pkg::ACTION_TOGGLE};
    hit(4);
    check(pa, 16'h0014);
    cap_val <= 16'h1234;
    cap_sel <= 1'b1;
    cap_stb <= 1'b1;
    @(posedge clk);
    cap_stb <= 1'b0;
    @(posedge clk) #1;
    check(cv[79:64], 16'h1234);
    cap_sel <= 1'b0;
    for (k = 0; k < 70000 && cnt !== 16'hFFFF; k++) @(posedge clk) #1;
    @(posedge clk) #1;
    check(cnt, 16'h0000);
    sel <= oct_pkg::PRESCALE_DIV8;
    rst_n <= 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (80) @(posedge clk);
    #1 check(cnt >= 16'h0009 && cnt <= 16'h000A, 16'h0001);
    complete_run;
  end
endmodule
bind oct_timer oct_timer_asserts oct_timer_asserts_i (.CORE_CLK, .RESET_N, .PRESCALE_SEL, .COMPARE_WDATA,
  .COMPARE_WE, .MULTI_PIN_SELECT, .MULTI_PIN_DATA, .TIMER_CONTROL, .TIMER_MASK, .FLAG_CLEAR,
  .FREE_RUNNING_COUNTER, .MATCH_FLAG, .COMPARE_VALUES, .PORT_A_OUT, .IRQ);
